/* File: src/smr_ctrl.v */
/*
  Motion reference controller of a servo drive: interrupt positioning in
  position mode and ramped, zero-clamped speed reference in speed mode, with
  an APB register slave.
  Assumes terminal inputs are asynchronous, while the motor feedback and the
  pulse reference speed come from logic on REF_CLK.
*/
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "smr_consts.vh"

module smr_ctrl (
  // Clock and reset.
  input wire REF_CLK,
  input wire SRST,
  // APB slave.
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Digital input terminals.
  input wire DI_TENTH,
  input wire DI_IP_CANCEL,
  input wire DI_IP_INHIBIT,
  input wire DI_ZERO_CLAMP,
  input wire DI_SPEED_DIR,
  // Motor loop feedback and external position reference speed.
  input wire signed [16:0] MOTOR_SPEED,
  input wire signed [31:0] ENC_POS,
  input wire signed [16:0] POS_REF_SPEED,
  // Outputs to the motor loop and output terminals.
  output reg signed [16:0] SPEED_CMD,
  output reg CLAMP_ACTIVE,
  output reg IP_RUNNING,
  output reg DO_IP_DONE,
  output reg ALARM_ZERO_SPEED
);

  localparam IP_IDLE = 2'h0;
  localparam IP_RUN = 2'h1;
  localparam IP_DONE = 2'h2;

  // Registers written by software.
  reg [`SMR_CTRL_W-1:0] ctrl;
  reg [30:0] ip_disp;
  reg [16:0] ip_speed;
  reg [15:0] ip_ramp;
  reg signed [16:0] main_ref;
  reg signed [16:0] aux_ref;
  reg signed [16:0] serial_ref;
  reg signed [16:0] seg_ref;
  reg [15:0] accel_ms;
  reg [15:0] decel_ms;
  reg [16:0] ramp_ref;
  reg [15:0] clamp_gain;
  reg [16:0] clamp_start;

  // Terminal levels after synchronisation.
  wire [4:0] di_raw;
  wire [4:0] di_sync;
  wire ip_enable;
  wire ip_cancel;
  wire ip_inhibit;
  wire clamp_in;
  wire dir_switch;

  // Interrupt positioning state.
  reg [1:0] ip_state;
  reg ip_enable_d;
  reg cancel_seen;
  reg ip_neg;
  reg ip_decel;
  reg [30:0] ip_remain;
  reg [30:0] ip_accel_pulses;
  reg [32:0] pulse_frac;

  // Zero clamp state.
  reg signed [31:0] clamp_pos;

  // Combinational terms.
  wire pos_mode;
  wire ip_armed;
  wire trigger;
  wire at_zero;
  wire signed [16:0] ip_ramp_out;
  wire signed [16:0] spd_ramp_out;
  reg signed [16:0] ip_target;
  reg signed [16:0] speed_ref;
  reg clamp_req;
  reg signed [31:0] clamp_err;
  reg signed [16:0] clamp_err_sat;
  reg signed [33:0] clamp_prod;
  reg signed [16:0] clamp_cmd;
  reg [16:0] ip_mag;
  reg [32:0] next_frac;
  reg pulse;
  reg [31:0] rdata;
  reg rmapped;

  // Magnitude of a signed speed.
  function [16:0] mag;
    input signed [16:0] v;
    begin
      mag = v[16] ? (~v + 17'h00001) : v;
    end
  endfunction

  // Main source selection with the auxiliary term.
  function signed [16:0] pick_ref;
    input [2:0] main_src;
    input [2:0] aux_src;
    input signed [16:0] dig;
    input signed [16:0] aux;
    input signed [16:0] ser;
    input signed [16:0] seg;
    reg signed [16:0] base;
    reg signed [16:0] add;
    begin
      case (main_src)
        `SMR_SRC_SERIAL: base = ser;
        `SMR_SRC_MULTI_SEG: base = seg;
        default: base = dig;
      endcase
      case (aux_src)
        `SMR_AUX_DIGITAL: add = aux;
        `SMR_AUX_SERIAL: add = ser;
        default: add = 17'sh00000;
      endcase
      // Segmented speeds take no auxiliary term.
      pick_ref = (main_src == `SMR_SRC_MULTI_SEG) ? base : base + add;
    end
  endfunction

  // All terminal inputs cross into REF_CLK through the same filter.
  assign di_raw = {DI_SPEED_DIR, DI_ZERO_CLAMP, DI_IP_INHIBIT, DI_IP_CANCEL, DI_TENTH};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      smr_sync u_sync (
        .clk(REF_CLK),
        .srst(SRST),
        .din(di_raw[gi]),
        .dout(di_sync[gi])
      );
    end
  endgenerate
  assign ip_enable = di_sync[0];
  assign ip_cancel = di_sync[1];
  assign ip_inhibit = di_sync[2];
  assign clamp_in = di_sync[3];
  assign dir_switch = di_sync[4];

  // Interrupt positioning is live only when selected and not inhibited.
  assign pos_mode = ctrl[`SMR_F_POS_MODE];
  assign ip_armed = ctrl[`SMR_F_IP_SELECT] &
    ~(ctrl[`SMR_F_INHIBIT_ASSIGNED] & ip_inhibit);
  // The tenth input serves as the enable whatever else it was given.
  assign trigger = pos_mode & ip_armed & ip_enable & ~ip_enable_d;
  assign at_zero = (mag(MOTOR_SPEED) < `SMR_ZERO_SPEED_TH);

  // Move targets: full speed in the latched direction, creep once decelerating.
  always @* begin
    ip_mag = ip_decel ? `SMR_IP_CREEP : ip_speed;
    ip_target = ip_neg ? (~ip_mag + 17'h00001) : ip_mag;
    speed_ref = pick_ref(ctrl[`SMR_F_MAIN_SRC_HI:`SMR_F_MAIN_SRC_LO],
      ctrl[`SMR_F_AUX_SRC_HI:`SMR_F_AUX_SRC_LO], main_ref, aux_ref, serial_ref, seg_ref);
    if (dir_switch) begin
      speed_ref = ~speed_ref + 17'h00001;
    end
  end

  // Pulse accounting of the interrupt move from the commanded speed.
  always @* begin
    next_frac = pulse_frac + {16'h0000, mag(ip_ramp_out)};
    pulse = (next_frac >= `SMR_PULSE_DIV);
  end

  // Zero clamp: position error to the latched point, scaled by the gain.
  always @* begin
    case (ctrl[`SMR_F_CLAMP_FN_HI:`SMR_F_CLAMP_FN_LO])
      `SMR_CLAMP_ALWAYS: clamp_req = 1'b1;
      `SMR_CLAMP_TERMINAL: clamp_req = clamp_in;
      default: clamp_req = 1'b0;
    endcase
    clamp_req = clamp_req & ~pos_mode & (mag(speed_ref) < clamp_start);
    clamp_err = clamp_pos - ENC_POS;
    if (clamp_err > 32'sh0000FFFF) begin
      clamp_err_sat = 17'sh0FFFF;
    end else if (clamp_err < -32'sh0000FFFF) begin
      clamp_err_sat = -17'sh0FFFF;
    end else begin
      clamp_err_sat = clamp_err[16:0];
    end
    clamp_prod = clamp_err_sat * $signed({1'b0, clamp_gain});
    clamp_cmd = clamp_prod[`SMR_GAIN_SHIFT+16:`SMR_GAIN_SHIFT];
    // Inside one pulse the clamp stays quiet; outside it drives back.
    if (clamp_err <= 32'sh00000001 && clamp_err >= -32'sh00000001) begin
      clamp_cmd = 17'sh00000;
    end
  end

  // The interrupt move ramps from the present speed to the preset speed.
  smr_ramp u_ip_ramp (
    .clk(REF_CLK),
    .srst(SRST),
    .load(trigger & ~at_zero & (ip_state == IP_IDLE)),
    .load_val(MOTOR_SPEED),
    .target(ip_state == IP_RUN ? ip_target : 17'sh00000),
    .accel_ms(ip_ramp),
    .decel_ms(ip_ramp),
    .ref_speed(ip_speed),
    .speed(ip_ramp_out)
  );

  // Every speed-mode source, segments included, goes through this ramp.
  smr_ramp u_spd_ramp (
    .clk(REF_CLK),
    .srst(SRST),
    .load(clamp_req),
    .load_val(17'sh00000),
    .target(speed_ref),
    .accel_ms(accel_ms),
    .decel_ms(decel_ms),
    .ref_speed(ramp_ref),
    .speed(spd_ramp_out)
  );

  // Interrupt positioning sequence.
  always @(posedge REF_CLK) begin
    if (SRST) begin
      ip_state <= IP_IDLE;
      ip_enable_d <= 1'b0;
      cancel_seen <= 1'b0;
      ip_neg <= 1'b0;
      ip_decel <= 1'b0;
      ip_remain <= 31'h00000000;
      ip_accel_pulses <= 31'h00000000;
      pulse_frac <= 33'h000000000;
      ALARM_ZERO_SPEED <= 1'b0;
    end else begin
      ip_enable_d <= ip_enable;
      // Alarm is raised by a zero-speed trigger in idle and held until release;
      // triggers while a move runs or waits for rearm are ignored.
      if (trigger & at_zero & (ip_state == IP_IDLE)) begin
        ALARM_ZERO_SPEED <= 1'b1;
      end else if (~ip_enable) begin
        ALARM_ZERO_SPEED <= 1'b0;
      end
      case (ip_state)
        IP_IDLE: begin
          if (trigger & ~at_zero & ~ALARM_ZERO_SPEED) begin
            ip_state <= IP_RUN;
            ip_neg <= MOTOR_SPEED[16];
            ip_decel <= 1'b0;
            ip_remain <= ip_disp;
            ip_accel_pulses <= 31'h00000000;
            pulse_frac <= 33'h000000000;
          end
        end
        IP_RUN: begin
          if (pulse) begin
            pulse_frac <= next_frac - `SMR_PULSE_DIV;
            if (ip_remain != 31'h00000000) begin
              ip_remain <= ip_remain - 31'h00000001;
            end
            if (~ip_decel & (mag(ip_ramp_out) < ip_speed)) begin
              ip_accel_pulses <= ip_accel_pulses + 31'h00000001;
            end
          end else begin
            pulse_frac <= next_frac;
          end
          // Symmetric profile: brake once what is left is at most the run-up plus one pulse.
          if (ip_remain <= ip_accel_pulses + 31'h00000001) begin
            ip_decel <= 1'b1;
          end
          if (ip_remain == 31'h00000000) begin
            ip_state <= IP_DONE;
            cancel_seen <= 1'b0;
          end
        end
        IP_DONE: begin
          if (ip_cancel) begin
            cancel_seen <= 1'b1;
          end
          // Rearm only on trigger release, and after a cancel when required.
          if (~ip_enable & (cancel_seen | ip_cancel |
              ~ctrl[`SMR_F_IP_CANCEL_REQ])) begin
            ip_state <= IP_IDLE;
          end
        end
        default: ip_state <= IP_IDLE;
      endcase
    end
  end

  // Outputs to the motor loop; the clamp point is caught on clamp entry.
  always @(posedge REF_CLK) begin
    if (SRST) begin
      SPEED_CMD <= 17'sh00000;
      CLAMP_ACTIVE <= 1'b0;
      IP_RUNNING <= 1'b0;
      DO_IP_DONE <= 1'b0;
      clamp_pos <= 32'sh00000000;
    end else begin
      CLAMP_ACTIVE <= clamp_req;
      IP_RUNNING <= (ip_state == IP_RUN);
      DO_IP_DONE <= (ip_state == IP_DONE);
      if (clamp_req & ~CLAMP_ACTIVE) begin
        clamp_pos <= ENC_POS;
      end
      if (ip_state == IP_DONE) begin
        SPEED_CMD <= 17'sh00000;
      end else if (ip_state == IP_RUN) begin
        SPEED_CMD <= (ip_remain == 31'h00000000) ? 17'sh00000 : ip_ramp_out;
      end else if (pos_mode) begin
        SPEED_CMD <= POS_REF_SPEED;
      end else if (clamp_req) begin
        SPEED_CMD <= (clamp_req & ~CLAMP_ACTIVE) ? 17'sh00000 : clamp_cmd;
      end else begin
        SPEED_CMD <= spd_ramp_out;
      end
    end
  end

  // Read decode; unmapped offsets answer with an error.
  always @* begin
    rdata = 32'h00000000;
    rmapped = 1'b1;
    case (PADDR)
      `SMR_A_CTRL: rdata = {20'h00000, ctrl};
      `SMR_A_IP_DISP: rdata = {1'b0, ip_disp};
      `SMR_A_IP_SPEED: rdata = {15'h0000, ip_speed};
      `SMR_A_IP_RAMP: rdata = {16'h0000, ip_ramp};
      `SMR_A_MAIN_REF: rdata = {15'h0000, main_ref};
      `SMR_A_AUX_REF: rdata = {15'h0000, aux_ref};
      `SMR_A_SERIAL_REF: rdata = {15'h0000, serial_ref};
      `SMR_A_SEG_REF: rdata = {15'h0000, seg_ref};
      `SMR_A_ACCEL: rdata = {16'h0000, accel_ms};
      `SMR_A_DECEL: rdata = {16'h0000, decel_ms};
      `SMR_A_RAMP_REF: rdata = {15'h0000, ramp_ref};
      `SMR_A_CLAMP_GAIN: rdata = {16'h0000, clamp_gain};
      `SMR_A_CLAMP_START: rdata = {15'h0000, clamp_start};
      `SMR_A_STATUS: rdata = {25'h0000000, cancel_seen, ALARM_ZERO_SPEED,
        CLAMP_ACTIVE, DO_IP_DONE, IP_RUNNING, ip_state};
      `SMR_A_SPEED_OUT: rdata = {15'h0000, SPEED_CMD};
      default: rmapped = 1'b0;
    endcase
  end

  // APB slave: the answer is prepared in the setup cycle, so each access
  // phase lasts exactly one cycle; writes land at the completing edge.
  always @(posedge REF_CLK) begin
    if (SRST) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      ctrl <= `SMR_RST_CTRL;
      ip_disp <= `SMR_RST_IP_DISP;
      ip_speed <= `SMR_RST_IP_SPEED;
      ip_ramp <= `SMR_RST_IP_RAMP;
      main_ref <= 17'sh00000;
      aux_ref <= 17'sh00000;
      serial_ref <= 17'sh00000;
      seg_ref <= 17'sh00000;
      accel_ms <= `SMR_RST_ACCEL;
      decel_ms <= `SMR_RST_DECEL;
      ramp_ref <= `SMR_RST_RAMP_REF;
      clamp_gain <= `SMR_RST_CLAMP_GAIN;
      clamp_start <= `SMR_RST_CLAMP_START;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~rmapped;
      if (PSEL & ~PENABLE & ~PWRITE) begin
        PRDATA <= rdata;
      end
      if (PSEL & PENABLE & PREADY & PWRITE & rmapped) begin
        case (PADDR)
          `SMR_A_CTRL: ctrl <= PWDATA[`SMR_CTRL_W-1:0];
          `SMR_A_IP_DISP: ip_disp <= PWDATA[30:0];
          `SMR_A_IP_SPEED: ip_speed <= PWDATA[16:0];
          `SMR_A_IP_RAMP: ip_ramp <= PWDATA[15:0];
          `SMR_A_MAIN_REF: main_ref <= PWDATA[16:0];
          `SMR_A_AUX_REF: aux_ref <= PWDATA[16:0];
          `SMR_A_SERIAL_REF: serial_ref <= PWDATA[16:0];
          `SMR_A_SEG_REF: seg_ref <= PWDATA[16:0];
          `SMR_A_ACCEL: accel_ms <= PWDATA[15:0];
          `SMR_A_DECEL: decel_ms <= PWDATA[15:0];
          `SMR_A_RAMP_REF: ramp_ref <= PWDATA[16:0];
          `SMR_A_CLAMP_GAIN: clamp_gain <= PWDATA[15:0];
          `SMR_A_CLAMP_START: clamp_start <= PWDATA[16:0];
          default: ctrl <= ctrl;
        endcase
      end
    end
  end

endmodule // smr_ctrl

`default_nettype wire

/* File: src/smr_consts.vh */
/*
  Constants of the servo motion reference block: register offsets, field
  positions, reset values and timing counts.
  Assumes a 200 MHz reference clock and speeds held in units of 0.1 rpm.
*/
`ifndef SMR_CONSTS_VH
`define SMR_CONSTS_VH

// Clock rate and the derived count of cycles in one millisecond.
`define SMR_CLK_MHZ 200
`define SMR_MS_PER_TICK 1
`define SMR_CYC_PER_MS (`SMR_CLK_MHZ * 1000 * `SMR_MS_PER_TICK)

// Register byte offsets on the APB.
`define SMR_A_CTRL 8'h00
`define SMR_A_IP_DISP 8'h04
`define SMR_A_IP_SPEED 8'h08
`define SMR_A_IP_RAMP 8'h0C
`define SMR_A_MAIN_REF 8'h10
`define SMR_A_AUX_REF 8'h14
`define SMR_A_SERIAL_REF 8'h18
`define SMR_A_SEG_REF 8'h1C
`define SMR_A_ACCEL 8'h20
`define SMR_A_DECEL 8'h24
`define SMR_A_RAMP_REF 8'h28
`define SMR_A_CLAMP_GAIN 8'h2C
`define SMR_A_CLAMP_START 8'h30
`define SMR_A_STATUS 8'h34
`define SMR_A_SPEED_OUT 8'h38

// Fields of the control register.
`define SMR_F_POS_MODE 0
`define SMR_F_IP_SELECT 1
`define SMR_F_IP_CANCEL_REQ 2
`define SMR_F_INHIBIT_ASSIGNED 3
`define SMR_F_CLAMP_FN_LO 4
`define SMR_F_CLAMP_FN_HI 5
`define SMR_F_MAIN_SRC_LO 6
`define SMR_F_MAIN_SRC_HI 8
`define SMR_F_AUX_SRC_LO 9
`define SMR_F_AUX_SRC_HI 11
`define SMR_CTRL_W 12

// Reset values.
`define SMR_RST_CTRL 12'h004
`define SMR_RST_IP_DISP 31'h00002710
`define SMR_RST_IP_SPEED 17'h007D0
`define SMR_RST_IP_RAMP 16'h000A
`define SMR_RST_ACCEL 16'h03E8
`define SMR_RST_DECEL 16'h03E8
`define SMR_RST_RAMP_REF 17'h07530
`define SMR_RST_CLAMP_GAIN 16'h0400
`define SMR_RST_CLAMP_START 17'h00014

// Source and clamp encodings.
`define SMR_SRC_DIGITAL 3'h0
`define SMR_SRC_SERIAL 3'h3
`define SMR_SRC_MULTI_SEG 3'h4
`define SMR_AUX_NONE 3'h0
`define SMR_AUX_DIGITAL 3'h1
`define SMR_AUX_SERIAL 3'h4
`define SMR_CLAMP_OFF 2'h0
`define SMR_CLAMP_ALWAYS 2'h1
`define SMR_CLAMP_TERMINAL 2'h2

// Motion scaling: speed units summed per position pulse, creep speed near the
// end of an interrupt move, and the speed below which the motor counts as still.
`define SMR_PULSE_DIV 33'h000004E20
`define SMR_IP_CREEP 17'h0000A
`define SMR_ZERO_SPEED_TH 17'h0000A
`define SMR_GAIN_SHIFT 10

`endif

/* File: src/smr_sync.v */
/*
  Three-stage synchroniser for one terminal input.
  Assumes the input is asynchronous to REF_CLK; the output moves only once the
  second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none

module smr_sync (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Raw and filtered level.
  input wire din,
  output reg dout
);

  reg s1;
  reg s2;
  reg s3;

  // The first stage feeds only the second, so metastability stays contained.
  always @(posedge clk) begin
    if (srst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end

endmodule // smr_sync

`default_nettype wire

/* File: src/smr_ramp.v */
/*
  Linear speed ramp generator with separate acceleration and deceleration times.
  Assumes speeds in 0.1 rpm units and times in milliseconds; a time of zero
  passes the target through in one step.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smr_consts.vh"

module smr_ramp (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Preload of the output, used to start from the present speed.
  input wire load,
  input wire signed [16:0] load_val,
  // Ramp settings.
  input wire signed [16:0] target,
  input wire [15:0] accel_ms,
  input wire [15:0] decel_ms,
  input wire [16:0] ref_speed,
  // Ramped speed.
  output reg signed [16:0] speed
);

  reg [33:0] acc;
  reg going_up;
  reg accel;
  reg [33:0] period;
  reg [33:0] next_acc;

  // Slope is ref_speed per programmed time, so reaching a speed s takes
  // (s / ref_speed) * time.
  always @* begin
    going_up = (target > speed);
    accel = going_up ? (speed >= 17'sh00000) : (speed <= 17'sh00000);
    period = accel ? (accel_ms * `SMR_CYC_PER_MS) : (decel_ms * `SMR_CYC_PER_MS);
    next_acc = acc + {17'h00000, ref_speed};
  end

  // One speed unit per overflow of the fractional accumulator.
  always @(posedge clk) begin
    if (srst) begin
      acc <= 34'h000000000;
      speed <= 17'sh00000;
    end else if (load) begin
      acc <= 34'h000000000;
      speed <= load_val;
    end else if (target == speed) begin
      acc <= 34'h000000000;
    end else if (period == 34'h000000000) begin
      speed <= target;
    end else if (next_acc >= period) begin
      acc <= next_acc - period;
      speed <= going_up ? speed + 17'sh00001 : speed - 17'sh00001;
    end else begin
      acc <= next_acc;
    end
  end

endmodule // smr_ramp

`default_nettype wire

/* File: testbench/smr_motor_model.sv */
/* Motor and encoder model on the far side of the motion reference block.
   Assumes one pulse per SMR_PULSE_DIV speed units summed per cycle. */
`timescale 1ns/1ps
`default_nettype none
`include "smr_consts.vh"
module smr_motor_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Command in, external displacement in pulses.
  input wire logic signed [16:0] speed_cmd,
  input wire logic signed [31:0] kick,
  // Feedback out.
  output logic signed [16:0] motor_speed,
  output logic signed [31:0] enc_pos
);
  localparam logic signed [33:0] PD = {1'b0, `SMR_PULSE_DIV};
  logic signed [33:0] acc;
  logic signed [33:0] next_acc;
  logic signed [31:0] pos;
  // Sum of speed before the pulse decision.
  always @* next_acc = acc + speed_cmd;
  // Ideal load: speed lags the command one cycle, so a still motor is seen as still.
  always @(posedge clk) begin
    if (srst) begin
      motor_speed <= 17'h00000;
      acc <= 34'h000000000;
      pos <= 32'h00000000;
    end else begin
      motor_speed <= speed_cmd;
      if (next_acc >= PD) begin
        acc <= next_acc - PD;
        pos <= pos + 32'h00000001;
      end else if (next_acc <= -PD) begin
        acc <= next_acc + PD;
        pos <= pos - 32'h00000001;
      end else begin
        acc <= next_acc;
      end
    end
  end
  // A kick stands for an external force moving the shaft.
  assign enc_pos = pos + kick;
endmodule // smr_motor_model
`default_nettype wire

/* File: testbench/smr_ctrl_asserts.sv */
/* Port checker of the motion reference controller.
   Assumes one clock, REF_CLK, and synchronous reset SRST. */
`timescale 1ns/1ps
`default_nettype none
module smr_ctrl_asserts (
  // Clock and reset.
  input wire REF_CLK,
  input wire SRST,
  // APB.
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  // Terminals and outputs.
  input wire DI_TENTH,
  input wire signed [16:0] SPEED_CMD,
  input wire CLAMP_ACTIVE,
  input wire IP_RUNNING,
  input wire DO_IP_DONE,
  input wire ALARM_ZERO_SPEED
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // A raw enable held six cycles has passed the filter, so no rearm can occur.
  apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("long ready");
  ready_cause_a: assert property (PREADY |-> $past(PSEL && !PENABLE)) else $error("stray ready");
  slverr_ready_a: assert property (PSLVERR |-> PREADY) else $error("stray error");
  done_stop_a: assert property (DO_IP_DONE |-> SPEED_CMD == 17'h00000) else $error("moving");
  run_done_a: assert property (!(IP_RUNNING && DO_IP_DONE)) else $error("run and done");
  run_end_a: assert property ($fell(IP_RUNNING) |-> ##[0:2] DO_IP_DONE) else $error("no done");
  done_hold_a: assert property (DI_TENTH [*6] ##0 DO_IP_DONE |=> DO_IP_DONE) else $error("done");
  alarm_hold_a: assert property (DI_TENTH [*6] ##0 ALARM_ZERO_SPEED |=> ALARM_ZERO_SPEED)
    else $error("alarm dropped");
  alarm_run_a: assert property ($rose(ALARM_ZERO_SPEED) |-> !IP_RUNNING) else $error("alarm run");
  clamp_zero_a: assert property ($rose(CLAMP_ACTIVE) |-> ##[0:1] SPEED_CMD == 17'h00000)
    else $error("clamp speed");
endmodule // smr_ctrl_asserts
bind smr_ctrl smr_ctrl_asserts i_smr_ctrl_asserts (.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .DI_TENTH(DI_TENTH),
  .SPEED_CMD(SPEED_CMD), .CLAMP_ACTIVE(CLAMP_ACTIVE), .IP_RUNNING(IP_RUNNING),
  .DO_IP_DONE(DO_IP_DONE), .ALARM_ZERO_SPEED(ALARM_ZERO_SPEED));
`default_nettype wire

/* File: testbench/servo_motion_reference_ctrl_test.sv */
/* Self-checking bench of the motion reference controller.
   Assumes the motor model closes the loop and APB answers within 20 cycles. */
`timescale 1ns/1ps
`default_nettype none
module servo_motion_reference_ctrl_test;
  logic clk, srst, psel, penable, pwrite, tenth, cancel, inhibit, clampin, dir, err;
  logic pready, pslverr, clamp_act, running, done, alarm;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [16:0] pos_ref, speed_cmd, motor_speed;
  logic signed [31:0] enc_pos, kick, start;
  int miscompares, comparisons, seed, i, m, a, s, g;
  int ex [3];
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30};
  int rv [9] = '{4, 10000, 2000, 10, 1000, 1000, 30000, 1024, 20};
  logic [31:0] cv [3] = '{32'h00000204, 32'h000002C4, 32'h00000304};
  smr_ctrl i_smr_ctrl (.REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DI_TENTH(tenth), .DI_IP_CANCEL(cancel), .DI_IP_INHIBIT(inhibit),
    .DI_ZERO_CLAMP(clampin), .DI_SPEED_DIR(dir), .MOTOR_SPEED(motor_speed), .ENC_POS(enc_pos),
    .POS_REF_SPEED(pos_ref), .SPEED_CMD(speed_cmd), .CLAMP_ACTIVE(clamp_act),
    .IP_RUNNING(running), .DO_IP_DONE(done), .ALARM_ZERO_SPEED(alarm));
  smr_motor_model i_smr_motor_model (.clk(clk), .srst(srst), .speed_cmd(speed_cmd),
    .kick(kick), .motor_speed(motor_speed), .enc_pos(enc_pos));
  // Clock of 5 ns.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Verdict and end of the run.
  task automatic test_done;
    $display("Counts: %0d mismatches, %0d comparisons", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One comparison of a value or a flag.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request stands until ready is sampled.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      test_done();
    end
  endtask
  function automatic logic flag(input int k);
    case (k)
      0: return running;
      1: return done;
      2: return alarm;
      default: return clamp_act;
    endcase
  endfunction
  // Bounded wait for an output flag to reach a level.
  task automatic wt(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (flag(k) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(flag(k), v);
    if (flag(k) !== v) test_done();
  endtask
  // Main sequence; a ramp of 1 ms at reference 1000 moves 1 unit per 200 cycles.
  initial begin
    {psel, penable, pwrite, tenth, cancel, inhibit, clampin, dir} = '0;
    paddr = '0;
    pwdata = '0;
    pos_ref = '0;
    kick = '0;
    srst = 1'b1;
    seed = 1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 9; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, 32'(rv[i]));
    end
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h28, 32'd1000);
    apb(1'b1, 8'h20, 32'd1);
    apb(1'b1, 8'h10, 32'd50);
    repeat (5000) @(posedge clk);
    chk(speed_cmd >= 23 && speed_cmd <= 27, 1);
    repeat (5400) @(posedge clk);
    chk(32'(speed_cmd), 32'd50);
    apb(1'b1, 8'h20, 32'd0);
    apb(1'b1, 8'h24, 32'd0);
    m = 100 + ($random(seed) & 255);
    a = $random(seed) & 255;
    s = 100 + ($random(seed) & 255);
    g = 100 + ($random(seed) & 255);
    ex = '{m + a, s + a, g};
    apb(1'b1, 8'h10, 32'(m));
    apb(1'b1, 8'h14, 32'(a));
    apb(1'b1, 8'h18, 32'(s));
    apb(1'b1, 8'h1C, 32'(g));
    for (i = 0; i < 3; i++) begin
      apb(1'b1, 8'h00, cv[i]);
      repeat (4) @(posedge clk);
      chk(32'(speed_cmd), 32'(ex[i]));
    end
    // The direction terminal negates whichever source is selected.
    dir <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(speed_cmd), -32'(g));
    dir <= 1'b0;
    apb(1'b1, 8'h04, 32'd20);
    apb(1'b1, 8'h0C, 32'd0);
    pos_ref <= 17'(200 + ($random(seed) & 255));
    apb(1'b1, 8'h00, 32'h7);
    repeat (10) @(posedge clk);
    start = enc_pos;
    tenth <= 1'b1;
    wt(0, 1'b1, 20);
    pos_ref <= -17'sd300;
    repeat (3) @(posedge clk);
    chk(speed_cmd > 0, 1);
    wt(1, 1'b1, 30000);
    chk(enc_pos - start >= 19 && enc_pos - start <= 22, 1);
    tenth <= 1'b0;
    repeat (8) @(posedge clk);
    tenth <= 1'b1;
    repeat (30) @(posedge clk);
    chk({done, running}, 2'b10);
    cancel <= 1'b1;
    repeat (8) @(posedge clk);
    cancel <= 1'b0;
    tenth <= 1'b0;
    wt(1, 1'b0, 20);
    apb(1'b1, 8'h00, 32'h3);
    tenth <= 1'b1;
    wt(0, 1'b1, 20);
    repeat (3) @(posedge clk);
    chk(speed_cmd < 0, 1);
    wt(1, 1'b1, 30000);
    tenth <= 1'b0;
    wt(1, 1'b0, 20);
    apb(1'b1, 8'h00, 32'hB);
    inhibit <= 1'b1;
    tenth <= 1'b1;
    repeat (40) @(posedge clk);
    chk(running, 1'b0);
    tenth <= 1'b0;
    inhibit <= 1'b0;
    pos_ref <= '0;
    apb(1'b1, 8'h00, 32'h7);
    repeat (10) @(posedge clk);
    tenth <= 1'b1;
    wt(2, 1'b1, 20);
    repeat (20) @(posedge clk);
    chk({alarm, running}, 2'b10);
    tenth <= 1'b0;
    wt(2, 1'b0, 20);
    clampin <= 1'b1;
    apb(1'b1, 8'h10, 32'd5);
    apb(1'b1, 8'h00, 32'h24);
    wt(3, 1'b1, 20);
    chk(32'(speed_cmd), 32'd0);
    apb(1'b1, 8'h2C, 32'd2048);
    kick <= 32'sd8;
    repeat (4) @(posedge clk);
    chk(32'(speed_cmd), -32'sd16);
    kick <= 32'sd1;
    repeat (4) @(posedge clk);
    chk(32'(speed_cmd), 32'd0);
    test_done();
  end
  // Watchdog against a hung run.
  initial begin
    #450us;
    miscompares++;
    test_done();
  end
endmodule // servo_motion_reference_ctrl_test
`default_nettype wire
